// >>> inc/pcfg_regs.svh
`ifndef PCFG_REGS_SVH
`define PCFG_REGS_SVH

// Configuration space byte offsets
`define PCFG_OFF_MAKER_ID      8'h00
`define PCFG_OFF_PRODUCT_ID    8'h02
`define PCFG_OFF_COMMAND       8'h04
`define PCFG_OFF_STATUS        8'h06

// Command register fields
`define PCFG_CMD_IO_EN         0
`define PCFG_CMD_MEM_EN        1
`define PCFG_CMD_MASTER_EN     2
`define PCFG_CMD_PERR_EN       6
`define PCFG_CMD_SERR_EN       8
`define PCFG_CMD_B2B_EN        9
`define PCFG_CMD_WR_MASK       16'h0147
`define PCFG_CMD_RESET         16'h0000

// Status register fields
`define PCFG_STA_DET_PERR      15
`define PCFG_STA_SIG_SERR      14
`define PCFG_STA_MABORT        13
`define PCFG_STA_TABORT        12
`define PCFG_STA_TABORT_SENT   11
`define PCFG_STA_DATA_PERR     8
`define PCFG_STA_FIXED         16'h0290
`define PCFG_STA_W1C_MASK      16'hF100
`define PCFG_STA_STICKY_RESET  5'h00

// Bus commands on the command/byte-enable lines
`define PCFG_BUSCMD_CFG_RD     4'hA
`define PCFG_BUSCMD_CFG_WR     4'hB

`endif

// >>> inc/pcfg_pkg.sv
package pcfg_pkg;

   typedef logic [15:0] pcfg_word_t;

   typedef struct packed {
      logic        frame_n;
      logic        irdy_n;
      logic        idsel;
      logic [31:0] ad;
      logic [3:0]  cbe_n;
      logic        par;
   } pcfg_pci_in_s;

   typedef struct packed {
      logic [31:0] ad;
      logic        ad_oe;
      logic        par;
      logic        par_oe;
      logic        devsel_n;
      logic        trdy_n;
      logic        stop_n;
      logic        ctl_oe;
      logic        perr_n;
      logic        perr_oe;
      logic        serr_n;
      logic        serr_oe;
   } pcfg_pci_out_s;

   typedef struct packed {
      logic master_abort;
      logic target_abort;
      logic rd_data_perr;
      logic wr_perr_seen;
   } pcfg_mstr_evt_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DECODE,
      ST_DATA,
      ST_FINISH,
      ST_TURN
   } pcfg_state_e;

endpackage : pcfg_pkg

// >>> rtl/pcfg_cmd_reg.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_regs.svh"

module pcfg_cmd_reg (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              wr_en,
   input  wire logic [1:0]        be,
   input  wire pcfg_pkg::pcfg_word_t wdata,
   output var  pcfg_pkg::pcfg_word_t cmd_q
);
   import pcfg_pkg::*;

   localparam pcfg_word_t WR_MASK = `PCFG_CMD_WR_MASK;
   localparam pcfg_word_t RST_VAL = `PCFG_CMD_RESET;

   genvar lane;
   generate
      for (lane = 0; lane < 2; lane++) begin : g_lane
         // Hardware reset only; soft reset and stop never reach here
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cmd_q[lane*8 +: 8] <= RST_VAL[lane*8 +: 8];
            end else if (wr_en && be[lane]) begin
               cmd_q[lane*8 +: 8] <= wdata[lane*8 +: 8] & WR_MASK[lane*8 +: 8];
            end
         end
      end
   endgenerate

endmodule : pcfg_cmd_reg
`default_nettype wire

// >>> rtl/pcfg_sticky.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_regs.svh"

module pcfg_sticky #(
   parameter int W = 5
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output var  logic [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // A set arriving with the clear wins, so no event is lost
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               q[i] <= 1'b0;
            end else if (set[i]) begin
               q[i] <= 1'b1;
            end else if (clr[i]) begin
               q[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule : pcfg_sticky
`default_nettype wire

// >>> rtl/pcfg_top.sv
// Summary of operation
// - Offset 0 reads a 16-bit maker ID mirroring the EEPROM-loadable internal register.
// - Offset 2 reads a fixed 16-bit product ID; writes do nothing.
// - Command zero stops all bus activity except configuration cycles.
// - Command bit 9 reads zero; no fast back-to-back mastering.
// - Address parity error asserts SERR and status 14 only if bits 8 and 6 set.
// - Parity errors always set detected parity; PERR driven only with response enabled.
// - Writable command bits clear on hardware reset only.
// - Command bit 2 permits bus mastering; host sets it before starting.
// - Memory-space enable clear means all memory accesses, ROM included, are ignored.
// - ROM accesses claimed only with ROM enable and memory-space enable both set.
// - I/O-space enable clear means all I/O accesses are ignored.
// - Command bits 5-3, 15-10, 7 and reserved status bits read zero.
// - Status 15 sets on any detected parity error regardless of response enable.
// - Status 15,14,13,12,8 clear by writing one; hardware reset clears them.
// - Status 13 sets when own master cycle ends with master abort.
// - Status 12 sets when a target aborts an own master cycle.
// - Status 11 reads zero; slave never target-aborts.
// - Status 10-9 read 01b; DEVSEL asserted two clocks after FRAME.
// - Status 8 sets on master data parity errors with response enabled.
// - Status 7 reads one; fast back-to-back to other targets accepted.
// - Status 4 reads one; capability list present.
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_regs.svh"

module pcfg_top #(
   parameter logic [15:0] PRODUCT_ID = 16'h5A5A // Arbitrary value
) (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire pcfg_pkg::pcfg_pci_in_s   pci_in,
   output var  pcfg_pkg::pcfg_pci_out_s  pci_out,
   input  wire logic [15:0]              eeprom_loaded_maker_id,
   input  wire pcfg_pkg::pcfg_mstr_evt_s mstr_evt,
   input  wire logic                     io_addr_hit,
   input  wire logic                     mem_addr_hit,
   input  wire logic                     rom_addr_hit,
   input  wire logic                     expansion_rom_enable,
   input  wire logic                     master_req,
   output var  logic                     io_space_enable,
   output var  logic                     memory_space_enable,
   output var  logic                     bus_master_enable,
   output var  logic                     io_claim,
   output var  logic                     mem_claim,
   output var  logic                     rom_claim,
   output var  logic                     master_req_granted
);
   import pcfg_pkg::*;

   pcfg_state_e   state_q;
   logic [7:0]    addr_q;
   logic          is_write_q;
   logic          frame_prev_q;
   logic [35:0]   apar_data_q;
   logic          apar_chk_q;
   logic [35:0]   wpar_data_q;
   logic          wpar_chk_q;
   logic          perr_hold_q;
   pcfg_word_t    cmd_word;
   pcfg_word_t    status_word;
   logic [4:0]    sticky_q;
   logic [4:0]    sticky_set;
   logic [4:0]    sticky_clr;
   logic [3:0]    be;
   logic          start;
   logic          cfg_hit;
   logic          xfer;
   logic          addr_perr;
   logic          wr_perr;
   logic          perr_en;
   logic          serr_en;
   logic          cmdstat_sel;
   logic          ident_sel;
   logic          cmdstat_wr;
   logic          perr_fire;
   logic [31:0]   rdata;
   logic [31:0]   ad_q;
   logic          ad_oe_q;
   logic          par_q;
   logic          par_oe_q;
   logic          devsel_n_q;
   logic          trdy_n_q;
   logic          stop_n_q;
   logic          ctl_oe_q;
   logic          perr_n_q;
   logic          perr_oe_q;
   logic          serr_n_q;
   logic          serr_oe_q;

   // One driver for the whole output bundle; every field is a flop of its own concern
   assign pci_out = '{ad: ad_q, ad_oe: ad_oe_q, par: par_q, par_oe: par_oe_q, devsel_n: devsel_n_q,
                      trdy_n: trdy_n_q, stop_n: stop_n_q, ctl_oe: ctl_oe_q, perr_n: perr_n_q,
                      perr_oe: perr_oe_q, serr_n: serr_n_q, serr_oe: serr_oe_q};

   assign perr_en     = cmd_word[`PCFG_CMD_PERR_EN];
   assign serr_en     = cmd_word[`PCFG_CMD_SERR_EN];
   assign be          = ~pci_in.cbe_n;
   assign start       = !pci_in.frame_n && frame_prev_q;
   // Type 0, function 0 only: this is a single-function device
   assign cfg_hit     = pci_in.idsel && (pci_in.ad[1:0] == 2'b00) && (pci_in.ad[10:8] == 3'b000)
                        && (pci_in.cbe_n == `PCFG_BUSCMD_CFG_RD || pci_in.cbe_n == `PCFG_BUSCMD_CFG_WR);
   assign xfer        = (state_q == ST_DATA) && !pci_in.irdy_n;
   assign ident_sel   = ({addr_q[7:2], 2'b00} == `PCFG_OFF_MAKER_ID);
   assign cmdstat_sel = ({addr_q[7:2], 2'b00} == `PCFG_OFF_COMMAND);
   assign cmdstat_wr  = xfer && is_write_q && cmdstat_sel;
   assign addr_perr   = apar_chk_q && (pci_in.par != ^apar_data_q);
   assign wr_perr     = wpar_chk_q && (pci_in.par != ^wpar_data_q);
   assign perr_fire   = perr_en && (wr_perr || mstr_evt.rd_data_perr);

   pcfg_cmd_reg u_cmd (
      .clk    (clk),
      .arst_n (arst_n),
      .wr_en  (cmdstat_wr),
      .be     (be[1:0]),
      .wdata  (pci_in.ad[15:0]),
      .cmd_q  (cmd_word)
   );

   // Sticky order: det parity, signaled serr, master abort, target abort, data parity
   assign sticky_set[4] = addr_perr || wr_perr || mstr_evt.rd_data_perr || mstr_evt.wr_perr_seen;
   assign sticky_set[3] = addr_perr && serr_en && perr_en;
   assign sticky_set[2] = mstr_evt.master_abort;
   assign sticky_set[1] = mstr_evt.target_abort;
   assign sticky_set[0] = perr_en && (mstr_evt.rd_data_perr || mstr_evt.wr_perr_seen);
   assign sticky_clr[4] = cmdstat_wr && be[3] && pci_in.ad[16 + `PCFG_STA_DET_PERR];
   assign sticky_clr[3] = cmdstat_wr && be[3] && pci_in.ad[16 + `PCFG_STA_SIG_SERR];
   assign sticky_clr[2] = cmdstat_wr && be[3] && pci_in.ad[16 + `PCFG_STA_MABORT];
   assign sticky_clr[1] = cmdstat_wr && be[3] && pci_in.ad[16 + `PCFG_STA_TABORT];
   // Status bit 8 rides on AD[24], which belongs to the top byte lane
   assign sticky_clr[0] = cmdstat_wr && be[3] && pci_in.ad[16 + `PCFG_STA_DATA_PERR];

   pcfg_sticky #(
      .W (5)
   ) u_sticky (
      .clk    (clk),
      .arst_n (arst_n),
      .set    (sticky_set),
      .clr    (sticky_clr),
      .q      (sticky_q)
   );

   // Fixed fields: medium decode, b2b capable, capability list; rest zero
   always_comb begin
      status_word                        = `PCFG_STA_FIXED;
      status_word[`PCFG_STA_DET_PERR]    = sticky_q[4];
      status_word[`PCFG_STA_SIG_SERR]    = sticky_q[3];
      status_word[`PCFG_STA_MABORT]      = sticky_q[2];
      status_word[`PCFG_STA_TABORT]      = sticky_q[1];
      status_word[`PCFG_STA_DATA_PERR]   = sticky_q[0];
   end

   // Unimplemented configuration dwords read as zero
   always_comb begin
      if (ident_sel) begin
         rdata = {PRODUCT_ID, eeprom_loaded_maker_id};
      end else if (cmdstat_sel) begin
         rdata = {status_word, cmd_word};
      end else begin
         rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= ST_IDLE;
         addr_q     <= 8'h00;
         is_write_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start && cfg_hit) begin
                  state_q    <= ST_DECODE;
                  addr_q     <= pci_in.ad[7:0];
                  is_write_q <= (pci_in.cbe_n == `PCFG_BUSCMD_CFG_WR);
               end
            end
            ST_DECODE: begin
               state_q <= ST_DATA;
            end
            ST_DATA: begin
               if (xfer) begin
                  state_q <= pci_in.frame_n ? ST_TURN : ST_FINISH;
               end
            end
            ST_FINISH: begin
               if (pci_in.frame_n) begin
                  state_q <= ST_TURN;
               end
            end
            ST_TURN: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Every transfer disconnects after one data phase; bursts are stopped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ad_q       <= 32'h0000_0000;
         ad_oe_q    <= 1'b0;
         devsel_n_q <= 1'b1;
         trdy_n_q   <= 1'b1;
         stop_n_q   <= 1'b1;
         ctl_oe_q   <= 1'b0;
      end else begin
         case (state_q)
            ST_DECODE: begin
               devsel_n_q <= 1'b0;
               trdy_n_q   <= 1'b0;
               stop_n_q   <= 1'b0;
               ctl_oe_q   <= 1'b1;
               ad_oe_q    <= !is_write_q;
               ad_q       <= rdata;
            end
            ST_DATA: begin
               if (xfer) begin
                  trdy_n_q <= 1'b1;
                  ad_oe_q  <= 1'b0;
                  if (pci_in.frame_n) begin
                     devsel_n_q <= 1'b1;
                     stop_n_q   <= 1'b1;
                  end
               end
            end
            ST_FINISH: begin
               if (pci_in.frame_n) begin
                  devsel_n_q <= 1'b1;
                  stop_n_q   <= 1'b1;
               end
            end
            ST_TURN: begin
               ctl_oe_q <= 1'b0;
            end
            default: begin
               ctl_oe_q <= ctl_oe_q;
            end
         endcase
      end
   end

   // Parity trails its data by one clock on both directions
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         par_q        <= 1'b0;
         par_oe_q     <= 1'b0;
         frame_prev_q <= 1'b1;
         apar_chk_q   <= 1'b0;
         apar_data_q  <= 36'h0_0000_0000;
         wpar_chk_q   <= 1'b0;
         wpar_data_q  <= 36'h0_0000_0000;
      end else begin
         par_q        <= ^{ad_q, pci_in.cbe_n};
         par_oe_q     <= ad_oe_q;
         frame_prev_q <= pci_in.frame_n;
         apar_chk_q   <= start;
         apar_data_q  <= {pci_in.ad, pci_in.cbe_n};
         wpar_chk_q   <= xfer && is_write_q;
         wpar_data_q  <= {pci_in.ad, pci_in.cbe_n};
      end
   end

   // PERR low for one clock, then driven high one clock before release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         perr_n_q    <= 1'b1;
         perr_oe_q   <= 1'b0;
         perr_hold_q <= 1'b0;
         serr_n_q    <= 1'b0;
         serr_oe_q   <= 1'b0;
      end else begin
         perr_n_q    <= !perr_fire;
         perr_hold_q <= perr_fire;
         perr_oe_q   <= perr_fire || perr_hold_q;
         serr_n_q    <= 1'b0;
         serr_oe_q   <= addr_perr && serr_en && perr_en;
      end
   end

   // Claims rely on the host having set a valid base first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_space_enable     <= 1'b0;
         memory_space_enable <= 1'b0;
         bus_master_enable   <= 1'b0;
         io_claim            <= 1'b0;
         mem_claim           <= 1'b0;
         rom_claim           <= 1'b0;
         master_req_granted  <= 1'b0;
      end else begin
         io_space_enable     <= cmd_word[`PCFG_CMD_IO_EN];
         memory_space_enable <= cmd_word[`PCFG_CMD_MEM_EN];
         bus_master_enable   <= cmd_word[`PCFG_CMD_MASTER_EN];
         io_claim            <= cmd_word[`PCFG_CMD_IO_EN] && io_addr_hit;
         mem_claim           <= cmd_word[`PCFG_CMD_MEM_EN] && mem_addr_hit;
         rom_claim           <= cmd_word[`PCFG_CMD_MEM_EN] && expansion_rom_enable && rom_addr_hit;
         master_req_granted  <= cmd_word[`PCFG_CMD_MASTER_EN] && master_req;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_devsel_medium: assert property (state_q == ST_IDLE && start && cfg_hit |->
         pci_out.devsel_n ##1 pci_out.devsel_n ##1 !pci_out.devsel_n && !pci_out.trdy_n)
      else $error("DEVSEL not asserted two clocks after FRAME");
   chk_cmd_zero_bits: assert property ((cmd_word & ~`PCFG_CMD_WR_MASK) == 16'h0000)
      else $error("Read-only command bits not zero");
   chk_status_fixed: assert property ((status_word & ~`PCFG_STA_W1C_MASK) == `PCFG_STA_FIXED)
      else $error("Fixed status bits wrong");
   chk_serr_gate: assert property (addr_perr |=> pci_out.serr_oe == (serr_en && perr_en)
         && sticky_q[3] == ($past(serr_en && perr_en) || $past(sticky_q[3])))
      else $error("SERR not gated by both enables");
   chk_perr_drive: assert property (wr_perr && perr_en |=> !pci_out.perr_n && pci_out.perr_oe
         ##1 pci_out.perr_n && pci_out.perr_oe && sticky_q[4])
      else $error("PERR not driven after write parity error");
   chk_det_perr_any: assert property (mstr_evt.wr_perr_seen && !perr_en |=> sticky_q[4])
      else $error("Detected parity not set");
   chk_w1c_clear: assert property (cmdstat_wr && be[3] && pci_in.ad[29] && !mstr_evt.master_abort
         |=> !sticky_q[2])
      else $error("Write one did not clear master abort");
   chk_mabort_sticky: assert property (mstr_evt.master_abort |=> sticky_q[2] [*2])
      else $error("Master abort flag not held");
   chk_master_data_parity_flag_gate: assert property (mstr_evt.rd_data_perr && !sticky_q[0] && !cmdstat_wr
         |=> sticky_q[0] == $past(perr_en))
      else $error("Data parity flag gating wrong");
   chk_mem_ignore: assert property (!cmd_word[`PCFG_CMD_MEM_EN] |=> !mem_claim && !rom_claim)
      else $error("Memory access claimed while disabled");
   chk_io_ignore: assert property (!cmd_word[`PCFG_CMD_IO_EN] |=> !io_claim)
      else $error("I/O access claimed while disabled");
   chk_master_gate: assert property (master_req_granted |-> $past(bus_master_enable || cmd_word[2]))
      else $error("Master request passed without enable");
   chk_one_phase: assert property (!pci_out.trdy_n |->
         !pci_out.stop_n && !pci_out.devsel_n && pci_out.ctl_oe)
      else $error("Data phase without disconnect");
   chk_serr_quiet: assert property (!(addr_perr && serr_en && perr_en) |=> !pci_out.serr_oe)
      else $error("SERR driven without cause");
   chk_perr_quiet: assert property (!perr_en |=> pci_out.perr_n)
      else $error("PERR driven low with response disabled");
   chk_addr_perr_det: assert property (addr_perr |=> sticky_q[4])
      else $error("Address parity error not recorded");

endmodule : pcfg_top
`default_nettype wire

// >>> verification/pcfg_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module pcfg_host_model (
   input  wire logic                    clk,
   input  wire pcfg_pkg::pcfg_pci_out_s pci_out,
   output var  pcfg_pkg::pcfg_pci_in_s  pci_in,
   output var  logic                    rd_valid,
   output var  logic [31:0]             rd_data,
   output var  logic [3:0]              delay,
   output var  logic                    resp
);
   import pcfg_pkg::*;

   logic        frame_n  = 1'b1;
   logic        irdy_n   = 1'b1;
   logic        idsel    = 1'b0;
   logic [31:0] h_ad     = 32'h0000_0000;
   logic        h_ad_oe  = 1'b1;
   logic [3:0]  h_cbe    = 4'hF;
   logic        h_par    = 1'b0;
   logic        h_par_oe = 1'b1;

   // A released line shows the inverse of the last host value, so stale data never passes
   always_comb begin
      pci_in.frame_n = frame_n;
      pci_in.irdy_n  = irdy_n;
      pci_in.idsel   = idsel;
      pci_in.cbe_n   = h_cbe;
      pci_in.ad      = h_ad_oe ? h_ad : (pci_out.ad_oe ? pci_out.ad : ~h_ad);
      pci_in.par     = h_par_oe ? h_par : (pci_out.par_oe ? pci_out.par : ~h_par);
   end

   initial begin
      rd_valid = 1'b0;
      rd_data  = 32'h0000_0000;
      delay    = 4'h0;
      resp     = 1'b0;
   end

   // One single-phase configuration transfer; bad[1] spoils address parity, bad[0] data parity
   task automatic xfer(input logic wr, input logic [7:0] off, input logic [3:0] be_n,
                       input logic [31:0] wd, input logic [1:0] bad, input logic sel);
      logic [3:0] n;
      n = 4'h1;
      @(negedge clk);
      frame_n = 1'b0;
      idsel   = sel;
      h_ad    = {24'h00_0000, off};
      h_cbe   = wr ? 4'hB : 4'hA;
      @(negedge clk);
      h_par   = ^{h_ad, h_cbe} ^ bad[1];
      frame_n = 1'b1;
      irdy_n  = 1'b0;
      idsel   = 1'b0;
      h_cbe   = be_n;
      h_ad    = wd;
      h_ad_oe = wr;
      @(negedge clk);
      // Parity trails its data by one clock
      h_par    = ^{wd, be_n} ^ bad[0];
      h_par_oe = wr;
      do begin
         @(posedge clk);
         n = n + 4'h1;
      end while ((pci_out.trdy_n !== 1'b0 || pci_out.devsel_n !== 1'b0) && n < 4'h8);
      resp  = (pci_out.trdy_n === 1'b0 && pci_out.devsel_n === 1'b0);
      delay = n;
      if (resp && !wr) begin
         rd_valid <= 1'b1;
         rd_data  <= pci_in.ad;
      end
      @(negedge clk);
      irdy_n  = 1'b1;
      h_ad_oe = 1'b1;
      @(posedge clk);
      rd_valid <= 1'b0;
      @(negedge clk);
      // Parity is retaken only after the device has let go of it
      h_par_oe = 1'b1;
      @(negedge clk);
   endtask : xfer
endmodule : pcfg_host_model

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import pcfg_pkg::*;

   localparam logic [15:0] PID = 16'h3C96; // Arbitrary product code

   logic           clk;
   logic           arst_n;
   pcfg_pci_in_s   pci_in;
   pcfg_pci_out_s  pci_out;
   logic [15:0]    maker_id;
   pcfg_mstr_evt_s mstr_evt;
   logic           io_hit, mem_hit, rom_hit, rom_en, mreq;
   logic           io_en, mem_en, bm_en, io_claim, mem_claim, rom_claim, granted;
   logic           rd_valid, resp;
   logic [31:0]    rd_data;
   logic [3:0]     delay;
   logic [31:0]    exp_q[$];
   logic [31:0]    exp_rd;
   logic [15:0]    cmd_e, sta_e;
   int             errors, checks, cycles, serr_cnt, perr_cnt, serr_exp, perr_exp;

   pcfg_top #(.PRODUCT_ID(PID)) u_pcfg_top (
      .clk(clk), .arst_n(arst_n), .pci_in(pci_in), .pci_out(pci_out),
      .eeprom_loaded_maker_id(maker_id), .mstr_evt(mstr_evt), .io_addr_hit(io_hit),
      .mem_addr_hit(mem_hit), .rom_addr_hit(rom_hit), .expansion_rom_enable(rom_en),
      .master_req(mreq), .io_space_enable(io_en), .memory_space_enable(mem_en),
      .bus_master_enable(bm_en), .io_claim(io_claim), .mem_claim(mem_claim),
      .rom_claim(rom_claim), .master_req_granted(granted)
   );

   pcfg_host_model u_pcfg_host_model (
      .clk(clk), .pci_out(pci_out), .pci_in(pci_in), .rd_valid(rd_valid),
      .rd_data(rd_data), .delay(delay), .resp(resp)
   );

   task automatic final_report;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [7:0] off);
      exp_q.push_back(off == 8'h00 ? {PID, maker_id} : (off == 8'h04 ? {sta_e, cmd_e} : 32'h0));
      u_pcfg_host_model.xfer(1'b0, off, 4'h0, 32'h0, 2'b00, 1'b1);
   endtask : rd

   task automatic wrc(input logic [15:0] cmd, input logic [15:0] clr);
      cmd_e = cmd & 16'h0147;
      sta_e = sta_e & ~(clr & 16'hF100);
      u_pcfg_host_model.xfer(1'b1, 8'h04, 4'h0, {clr, cmd}, 2'b00, 1'b1);
   endtask : wrc

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      serr_cnt += (pci_out.serr_oe === 1'b1);
      perr_cnt += (pci_out.perr_oe === 1'b1 && pci_out.perr_n === 1'b0);
      if (cycles == 6000) begin
         errors++;
         final_report();
      end
   end

   // Watcher: each completed read takes the oldest expectation
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         exp_rd = exp_q.pop_front();
         check("read data", rd_data, exp_rd);
         check("read parity", 32'({pci_out.par_oe, pci_out.par}), 32'({1'b1, ^exp_rd}));
         check("devsel delay", 32'(delay), 32'h2);
      end
   end

   initial begin
      logic [15:0] cmd_tab[5];
      logic [15:0] par_tab[3];
      logic [6:0]  want;
      arst_n   = 1'b0;
      mstr_evt = '0;
      {io_hit, mem_hit, rom_hit, rom_en, mreq} = 5'h00;
      cmd_e    = 16'h0000;
      sta_e    = 16'h0290;
      void'($urandom(27037));
      maker_id = 16'($urandom);
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      rd(8'h04);
      rd(8'h00);
      maker_id = ~maker_id;
      u_pcfg_host_model.xfer(1'b1, 8'h00, 4'h0, 32'hFFFF_FFFF, 2'b00, 1'b1);
      u_pcfg_host_model.xfer(1'b1, 8'h08, 4'h0, 32'hFFFF_FFFF, 2'b00, 1'b1);
      rd(8'h00);
      rd(8'h08);
      cmd_tab = '{16'hFFFF, 16'h0002, 16'h0001, 16'h0004, 16'h0000};
      foreach (cmd_tab[k]) begin
         wrc(cmd_tab[k], 16'h0000);
         rd(8'h04);
         repeat (8) begin
            {io_hit, mem_hit, rom_hit, rom_en, mreq} = 5'($urandom);
            want = {cmd_e[0] & io_hit, cmd_e[1] & mem_hit, cmd_e[1] & rom_hit & rom_en, cmd_e[2] & mreq,
                    cmd_e[0], cmd_e[1], cmd_e[2]};
            @(negedge clk);
            check("claims", 32'({io_claim, mem_claim, rom_claim, granted, io_en, mem_en, bm_en}), 32'(want));
         end
      end
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            wrc(p != 0 ? 16'h0040 : 16'h0000, 16'hFFFF);
            mstr_evt = pcfg_mstr_evt_s'(4'h1 << k);
            @(negedge clk);
            mstr_evt = '0;
            sta_e = sta_e | (k == 3 ? 16'h2000 : (k == 2 ? 16'h1000 : (p != 0 ? 16'h8100 : 16'h8000)));
            perr_exp += (k == 1 && p != 0);
            wrc(cmd_e, 16'h0000);
            rd(8'h04);
         end
      end
      par_tab = '{16'h0140, 16'h0100, 16'h0040};
      foreach (par_tab[k]) begin
         wrc(par_tab[k], 16'hFFFF);
         u_pcfg_host_model.xfer(1'b0, 8'h04, 4'h0, 32'h0, 2'b10, 1'b0);
         check("refused", 32'(resp), 32'h0);
         sta_e = sta_e | (par_tab[k] == 16'h0140 ? 16'hC000 : 16'h8000);
         serr_exp += (par_tab[k] == 16'h0140);
         rd(8'h04);
         wrc(par_tab[k], 16'h8000);
         u_pcfg_host_model.xfer(1'b1, 8'h00, 4'h0, 32'h0, 2'b01, 1'b1);
         sta_e = sta_e | 16'h8000;
         perr_exp += par_tab[k][6];
         rd(8'h04);
      end
      check("serr pulses", 32'(serr_cnt), 32'(serr_exp));
      check("perr pulses", 32'(perr_cnt), 32'(perr_exp));
      wrc(16'h0147, 16'h0000);
      mstr_evt.master_abort = 1'b1;
      @(negedge clk);
      mstr_evt = '0;
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      cmd_e  = 16'h0000;
      sta_e  = 16'h0290;
      rd(8'h04);
      repeat (2) @(negedge clk);
      check("pending reads", 32'(exp_q.size()), 32'h0);
      final_report();
   end
endmodule : testbench

`default_nettype wire
